/* verilog/bus_guard_pkg.sv */
// shared constants, field layout and carrier types of the bus transfer protection unit
package bus_guard_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int NUM_STRUCT      = 16;   // protection structures per unit
    localparam int NUM_UNIT        = 3;    // per-master, shared, peripheral
    localparam int IDX_W           = 4;
    localparam int REGION_MIN_LOG2 = 5;    // smallest region: 32 bytes

    // unit numbering, also the status bit of each unit's fault
    localparam int UNIT_MASTER = 0;
    localparam int UNIT_SHARED = 1;
    localparam int UNIT_PERIPH = 2;

    // which attributes each class of unit checks (bit n = unit n)
    localparam logic [2:0] CHK_PC_UNITS   = 3'h6;
    localparam logic [2:0] CHK_SEC_UNITS  = 3'h6;
    localparam logic [2:0] CHK_USER_UNITS = 3'h5;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_MASK   = 12'h008;
    localparam logic [11:0] OFF_FADDR  = 12'h00C;
    localparam logic [11:0] OFF_FINFO  = 12'h010;
    localparam logic [3:0]  PAGE_FIRST = 4'h1;   // structures of unit 0 at 0x100
    localparam logic [3:0]  PAGE_LAST  = 4'h3;   // structures of unit 2 at 0x300

    // control fields
    localparam int CTRL_EN_LSB   = 0;   // [2:0] unit enable
    localparam int CTRL_DENY_LSB = 4;   // [6:4] deny on miss

    // structure attribute word fields
    localparam int ATTR_EN       = 0;
    localparam int ATTR_RD       = 1;
    localparam int ATTR_WR       = 2;
    localparam int ATTR_EX       = 3;
    localparam int ATTR_USER     = 4;
    localparam int ATTR_NSEC     = 5;
    localparam int ATTR_SIZE_LSB = 8;   // [12:8] log2 of region size
    localparam int ATTR_PC_LSB   = 16;  // [31:16] one bit per context

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ATTR_RST = 32'h0000_0000;
    localparam logic [31:0] BASE_RST = 32'h0000_0000;
    localparam logic [2:0]  MASK_RST = 3'h0;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       ex;
        logic       priv;
        logic       secure;
        logic [3:0] pc;
    } bus_attr_t;

    typedef struct packed {
        logic             hit;
        logic             allow;
        logic [IDX_W-1:0] idx;
    } verdict_t;

    typedef enum logic [1:0] {ST_IDLE, ST_PERIPH, ST_DONE} gate_state_t;

    // address inside the region given by base and log2 size (floor 32 bytes)
    function automatic logic region_hit(input logic [31:0] addr, input logic [31:0] base, input logic [4:0] sz);
        logic [4:0]  lg;
        logic [31:0] msk;
        lg  = (sz < 5'(REGION_MIN_LOG2)) ? 5'(REGION_MIN_LOG2) : sz;
        msk = 32'hFFFF_FFFF << lg;
        return ((addr ^ base) & msk) == 32'h0000_0000;
    endfunction : region_hit

endpackage : bus_guard_pkg

/* verilog/struct_scan.sv */
// one unit's ascending priority scan over its protection structures
`timescale 1ns/1ps
`default_nettype none
module struct_scan
    import bus_guard_pkg::*;
#(
    parameter bit CHK_PC   = 1'b0,
    parameter bit CHK_SEC  = 1'b0,
    parameter bit CHK_USER = 1'b0
) (
    input  wire logic [31:0]            addr,               // transfer address
    input  wire bus_guard_pkg::bus_attr_t attr,             // master attributes
    input  wire logic [31:0]            base [NUM_STRUCT],  // region bases
    input  wire logic [31:0]            acc  [NUM_STRUCT],  // attribute words
    output      bus_guard_pkg::verdict_t verdict            // decision
);
    import bus_guard_pkg::*;

    // ---------------------------------------------------------------
    // scan
    // ---------------------------------------------------------------
    // ascending loop, later hits overwrite: the highest index wins
    always_comb begin
        logic ok;
        ok      = 1'b0;
        verdict = '0;
        for (int i = 0; i < NUM_STRUCT; i++) begin
            ok = 1'b1;
            if (attr.rd && !acc[i][ATTR_RD]) ok = 1'b0;
            if (attr.wr && !acc[i][ATTR_WR]) ok = 1'b0;
            if (attr.ex && !acc[i][ATTR_EX]) ok = 1'b0;
            if (CHK_USER && !attr.priv && !acc[i][ATTR_USER]) ok = 1'b0;
            if (CHK_SEC && !attr.secure && !acc[i][ATTR_NSEC]) ok = 1'b0;
            if (CHK_PC && !acc[i][ATTR_PC_LSB + int'(attr.pc)]) ok = 1'b0;
            if (acc[i][ATTR_EN] && region_hit(addr, base[i], acc[i][ATTR_SIZE_LSB +: 5])) begin
                verdict.hit   = 1'b1;
                verdict.allow = ok;
                verdict.idx   = IDX_W'(i);
            end
        end
    end

endmodule : struct_scan
`default_nettype wire

/* verilog/event_flags.sv */
// sticky fault flags with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module event_flags
    import bus_guard_pkg::*;
(
    input  wire logic       pclk,      // clock
    input  wire logic       presetn,   // async reset, low
    input  wire logic [2:0] set,       // event pulses
    input  wire logic       clr_we,    // status write strobe
    input  wire logic       mask_we,   // mask write strobe
    input  wire logic [2:0] wdata,     // write data
    output      logic [2:0] status_q,  // sticky flags
    output      logic [2:0] mask_q,    // enable per flag
    output      logic       irq_q      // level interrupt
);
    import bus_guard_pkg::*;

    // set beats a simultaneous clear so no fault is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) status_q <= 3'h0;
        else          status_q <= (status_q & ~(clr_we ? wdata : 3'h0)) | set;
    end

    // mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)     mask_q <= MASK_RST;
        else if (mask_we) mask_q <= wdata;
    end

    // registered so the pin is glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_q <= 1'b0;
        else          irq_q <= |(status_q & mask_q);
    end

endmodule : event_flags
`default_nettype wire

/* verilog/bus_transfer_protection_unit.sv */
// top of the bus transfer protection unit: apb registers, three guards, gating sequencer
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bus_transfer_protection_unit
    import bus_guard_pkg::*;
(
    input  wire logic                     pclk,         // system bus clock
    input  wire logic                     presetn,      // async reset, low
    input  wire logic                     psel,         // apb select
    input  wire logic                     penable,      // apb access phase
    input  wire logic                     pwrite,       // apb write
    input  wire logic [11:0]              paddr,        // apb byte address
    input  wire logic [31:0]              pwdata,       // apb write data
    output      logic [31:0]              prdata,       // apb read data
    output      logic                     pready,       // apb ready
    output      logic                     pslverr,      // apb error
    input  wire logic                     xfer_valid,   // transfer request
    input  wire logic [31:0]              xfer_addr,    // transfer address
    input  wire bus_guard_pkg::bus_attr_t xfer_attr,    // master attributes
    input  wire logic                     xfer_periph,  // target is peripheral space
    output      logic                     xfer_ready,   // request taken
    output      logic                     resp_valid,   // decision pulse
    output      logic                     resp_error,   // bus error, transfer blocked
    output      logic                     irq           // fault interrupt
);
    import bus_guard_pkg::*;

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [31:0] base_q [NUM_UNIT][NUM_STRUCT];
    logic [31:0] acc_q  [NUM_UNIT][NUM_STRUCT];
    logic [31:0] ctrl_q;
    logic [31:0] faddr_q;
    logic [31:0] finfo_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        xfer_ready_q;
    logic        resp_valid_q;
    logic        resp_error_q;
    logic [31:0] hold_addr_q;
    bus_attr_t   hold_attr_q;
    gate_state_t state_q;
    logic [2:0]  flag_status;
    logic [2:0]  flag_mask;
    logic        irq_q;
    logic [2:0]  fault_set;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic       setup;
    logic       wr_en;
    logic       st_hit;
    logic       reg_hit;
    logic [1:0] st_unit;
    logic [3:0] st_idx;

    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite && pready_q;
    assign st_hit  = (paddr[11:8] >= PAGE_FIRST) && (paddr[11:8] <= PAGE_LAST) && !paddr[7];
    assign st_unit = 2'(paddr[11:8] - PAGE_FIRST);
    assign st_idx  = paddr[6:3];
    assign reg_hit = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_MASK)
                     || (paddr == OFF_FADDR) || (paddr == OFF_FINFO) || st_hit;

    // no wait state: answer built in setup, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !reg_hit;
            prdata_q  <= 32'h0000_0000;
            if (setup && !pwrite) begin
                if (st_hit)
                    prdata_q <= paddr[2] ? acc_q[st_unit][st_idx] : base_q[st_unit][st_idx];
                else if (paddr == OFF_CTRL)   prdata_q <= ctrl_q;
                else if (paddr == OFF_STATUS) prdata_q <= {29'h0, flag_status};
                else if (paddr == OFF_MASK)   prdata_q <= {29'h0, flag_mask};
                else if (paddr == OFF_FADDR)  prdata_q <= faddr_q;
                else if (paddr == OFF_FINFO)  prdata_q <= finfo_q;
            end
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                      ctrl_q <= CTRL_RST;
        else if (wr_en && paddr == OFF_CTRL) ctrl_q <= pwdata & 32'h0000_0077;
    end

    // each unit keeps its own structure set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int u = 0; u < NUM_UNIT; u++) begin
                for (int i = 0; i < NUM_STRUCT; i++) begin
                    base_q[u][i] <= BASE_RST;
                    acc_q[u][i]  <= ATTR_RST;
                end
            end
        end else if (wr_en && st_hit && !pslverr_q) begin
            if (paddr[2]) acc_q[st_unit][st_idx]  <= pwdata;
            else          base_q[st_unit][st_idx] <= {pwdata[31:5], 5'h00};
        end
    end

    // ---------------------------------------------------------------
    // guards
    // ---------------------------------------------------------------
    logic [31:0] unit_addr [NUM_UNIT];
    bus_attr_t   unit_attr [NUM_UNIT];
    verdict_t    verdict   [NUM_UNIT];
    logic [2:0]  deny;

    for (genvar u = 0; u < NUM_UNIT; u++) begin : g_unit
        // the peripheral guard sees only transfers the others let through
        assign unit_addr[u] = (u == UNIT_PERIPH || state_q != ST_IDLE) ? hold_addr_q : xfer_addr;
        assign unit_attr[u] = (u == UNIT_PERIPH || state_q != ST_IDLE) ? hold_attr_q : xfer_attr;

        struct_scan #(
            .CHK_PC   (CHK_PC_UNITS[u]),
            .CHK_SEC  (CHK_SEC_UNITS[u]),
            .CHK_USER (CHK_USER_UNITS[u])
        ) u_scan (
            .addr    (unit_addr[u]),
            .attr    (unit_attr[u]),
            .base    (base_q[u]),
            .acc     (acc_q[u]),
            .verdict (verdict[u])
        );

        // a miss falls back to the unit's default; a disabled unit passes all
        assign deny[u] = ctrl_q[CTRL_EN_LSB + u]
                         && (verdict[u].hit ? !verdict[u].allow : ctrl_q[CTRL_DENY_LSB + u]);
    end

    logic ms_deny;
    logic take;
    assign ms_deny = deny[UNIT_MASTER] || deny[UNIT_SHARED];
    assign take    = xfer_valid && xfer_ready_q;

    // ---------------------------------------------------------------
    // gating sequencer
    // ---------------------------------------------------------------
    // attributes arrive with every request and are held for the peripheral step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_addr_q <= 32'h0000_0000;
            hold_attr_q <= '0;
        end else if (take) begin
            hold_addr_q <= xfer_addr;
            hold_attr_q <= xfer_attr;
        end
    end

    // ready drops for the decision so requests never overlap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= ST_IDLE;
            xfer_ready_q <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_error_q <= 1'b0;
        end else begin
            resp_valid_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    xfer_ready_q <= 1'b1;
                    if (take) begin
                        xfer_ready_q <= 1'b0;
                        if (ms_deny || !xfer_periph) begin
                            resp_valid_q <= 1'b1;
                            resp_error_q <= ms_deny;
                            state_q      <= ST_DONE;
                        end else begin
                            state_q <= ST_PERIPH;
                        end
                    end
                end
                ST_PERIPH: begin
                    resp_valid_q <= 1'b1;
                    resp_error_q <= deny[UNIT_PERIPH];
                    state_q      <= ST_DONE;
                end
                ST_DONE: begin
                    xfer_ready_q <= 1'b1;
                    state_q      <= ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // fault capture
    // ---------------------------------------------------------------
    // only the first refusing unit is recorded, matching the precedence
    always_comb begin
        fault_set = 3'h0;
        if (state_q == ST_IDLE && take) begin
            if (deny[UNIT_MASTER])      fault_set[UNIT_MASTER] = 1'b1;
            else if (deny[UNIT_SHARED]) fault_set[UNIT_SHARED] = 1'b1;
        end else if (state_q == ST_PERIPH) begin
            fault_set[UNIT_PERIPH] = deny[UNIT_PERIPH];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faddr_q <= 32'h0000_0000;
            finfo_q <= 32'h0000_0000;
        end else if (fault_set[UNIT_MASTER]) begin
            faddr_q <= xfer_addr;
            finfo_q <= {22'h0, 2'(UNIT_MASTER), 2'h0, verdict[UNIT_MASTER].hit, 1'b0, verdict[UNIT_MASTER].idx};
        end else if (fault_set[UNIT_SHARED]) begin
            faddr_q <= xfer_addr;
            finfo_q <= {22'h0, 2'(UNIT_SHARED), 2'h0, verdict[UNIT_SHARED].hit, 1'b0, verdict[UNIT_SHARED].idx};
        end else if (fault_set[UNIT_PERIPH]) begin
            faddr_q <= hold_addr_q;
            finfo_q <= {22'h0, 2'(UNIT_PERIPH), 2'h0, verdict[UNIT_PERIPH].hit, 1'b0, verdict[UNIT_PERIPH].idx};
        end
    end

    event_flags u_flags (
        .pclk     (pclk),
        .presetn  (presetn),
        .set      (fault_set),
        .clr_we   (wr_en && paddr == OFF_STATUS),
        .mask_we  (wr_en && paddr == OFF_MASK),
        .wdata    (pwdata[2:0]),
        .status_q (flag_status),
        .mask_q   (flag_mask),
        .irq_q    (irq_q)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign xfer_ready = xfer_ready_q;
    assign resp_valid = resp_valid_q;
    assign resp_error = resp_error_q;
    assign irq        = irq_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take;
        xfer_valid && xfer_ready_q;
    endsequence

    sequence s_take_ms_deny;
        s_take ##0 ms_deny;
    endsequence

    sequence s_take_periph_ok;
        s_take ##0 (!ms_deny && xfer_periph);
    endsequence

    AST_ANSWER_BOUND: assert property (s_take |-> ##[1:2] resp_valid_q)
        else $error("transfer not decided within two cycles");
    AST_MS_DENY_ERR: assert property (s_take_ms_deny |=> resp_valid_q && resp_error_q)
        else $error("master or shared refusal not answered with error");
    AST_NO_PERIPH_STEP: assert property (s_take_ms_deny |=> state_q == ST_DONE)
        else $error("refused transfer went on to peripheral check");
    AST_PERIPH_PATH: assert property (s_take_periph_ok |=> !resp_valid_q ##1 (resp_valid_q
                                      && resp_error_q == $past(deny[UNIT_PERIPH])))
        else $error("peripheral decision wrong or mistimed");
    AST_PLAIN_PASS: assert property (s_take ##0 (!ms_deny && !xfer_periph)
                                     |=> resp_valid_q && !resp_error_q)
        else $error("permitted transfer refused");
    AST_NO_OVERLAP: assert property (resp_valid_q |-> !xfer_ready_q ##1 xfer_ready_q)
        else $error("ready not held low around decision");
    AST_FAULT_ADDR: assert property (s_take_ms_deny |=> faddr_q == $past(xfer_addr))
        else $error("fault address not captured");
    AST_APB_READY: assert property (psel && !penable |=> pready_q && (pslverr_q == !$past(reg_hit)))
        else $error("apb answer wrong");
    AST_IRQ_LEVEL: assert property (|(flag_status & flag_mask) |=> irq_q)
        else $error("unmasked fault without interrupt");
    AST_BASE_ALIGN: assert property (wr_en && st_hit && !paddr[2]
                                     |=> base_q[$past(st_unit)][$past(st_idx)][4:0] == 5'h00)
        else $error("region base not 32 byte aligned");

endmodule : bus_transfer_protection_unit
`default_nettype wire

/* verification/xfer_master_model.sv */
// bus master model: one protected transfer at a time, with its own attributes
`timescale 1ns/1ps
`default_nettype none
module xfer_master_model
    import bus_guard_pkg::*;
(
    input  wire logic                    pclk,         // system bus clock
    output var  logic                    xfer_valid,   // request
    output var  logic [31:0]             xfer_addr,    // target address
    output var  bus_guard_pkg::bus_attr_t xfer_attr,   // own attributes
    output var  logic                    xfer_periph,  // peripheral target
    input  wire logic                    xfer_ready,   // request taken
    input  wire logic                    resp_valid,   // decision pulse
    input  wire logic                    resp_error    // refused
);
    import bus_guard_pkg::*;

    // idle until the bench asks for a transfer
    initial begin
        xfer_valid  = 1'b0;
        xfer_addr   = 32'h0000_0000;
        xfer_attr   = 9'h000;
        xfer_periph = 1'b0;
    end

    // hold the request until taken, then wait a bounded time for the decision
    task automatic send(input int gap, input logic [31:0] a, input bus_attr_t t, input logic p, output logic e);
        int n;
        n = 0;
        e = 1'bx;
        repeat (gap) @(posedge pclk);
        xfer_valid  <= 1'b1;
        xfer_addr   <= a;
        xfer_attr   <= t;
        xfer_periph <= p;
        do begin
            @(posedge pclk);
            n++;
        end while (xfer_ready !== 1'b1 && n < 50);
        xfer_valid  <= 1'b0;
        xfer_addr   <= ~a;  // released lines carry no stale value
        xfer_attr   <= ~t;
        do begin
            @(posedge pclk);
            n++;
        end while (resp_valid !== 1'b1 && n < 50);
        if (resp_valid === 1'b1) e = resp_error;
    endtask : send
endmodule : xfer_master_model
`default_nettype wire

/* verification/bus_transfer_protection_unit_tb_top.sv */
// self-checking bench of the bus transfer protection unit
`timescale 1ns/1ps
`default_nettype none
module bus_transfer_protection_unit_tb_top;
    import bus_guard_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        xfer_valid, xfer_periph, xfer_ready, resp_valid, resp_error;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, xfer_addr, rdat;
    bus_attr_t   xfer_attr;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    // transfer table: address, attributes, peripheral, refusal, status after
    localparam logic [31:0] T_ADDR [9] = '{32'h1000, 32'h1020, 32'h1020, 32'h2000, 32'h2000,
                                          32'h2000, 32'h2000, 32'h3000, 32'h4000};
    localparam bus_attr_t   T_ATTR [9] = '{9'h0B1, 9'h0B1, 9'h111, 9'h0B2, 9'h0A1, 9'h0B1, 9'h0B2, 9'h0B1, 9'h0B1};
    localparam logic [8:0]  T_PER = 9'h1C0;
    localparam logic [8:0]  T_ERR = 9'h15A;
    localparam logic [2:0]  T_ST [9] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h2, 3'h0, 3'h2, 3'h0, 3'h4};

    bus_transfer_protection_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xfer_valid(xfer_valid), .xfer_addr(xfer_addr), .xfer_attr(xfer_attr), .xfer_periph(xfer_periph),
        .xfer_ready(xfer_ready), .resp_valid(resp_valid), .resp_error(resp_error), .irq(irq));
    xfer_master_model u_mst (.pclk(pclk), .xfer_valid(xfer_valid), .xfer_addr(xfer_addr), .xfer_attr(xfer_attr),
        .xfer_periph(xfer_periph), .xfer_ready(xfer_ready), .resp_valid(resp_valid), .resp_error(resp_error));

    // ----------------------------------------------------------------
    // clock, timeout and verdict
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // cut a hang short well beyond the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // compare and apb tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    // one setup and one access phase; trailing edge keeps psel from toggling twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) n_errors++;
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask : rd
    task automatic cfg(input int u, input int i, input logic [31:0] b, input logic [31:0] at);
        apb(1'b1, 12'((u + 1) * 256 + i * 8), b);
        apb(1'b1, 12'((u + 1) * 256 + i * 8 + 4), at);
    endtask : cfg

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr  = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(OFF_CTRL, CTRL_RST);
        rd(OFF_STATUS, 32'h0000_0000);
        rd(OFF_MASK, {29'h0, MASK_RST});
        rd(12'hFFC, 32'h0000_0000);
        chk_bit(err, 1'b1);
        u_mst.send(0, 32'h1020, 9'h0B1, 1'b0, err);
        chk_bit(err, 1'b0);
        // unit 0: wide read-only region under a narrow read-write one
        cfg(UNIT_MASTER, 3, 32'h1000, 32'h0000_0813);
        cfg(UNIT_MASTER, 15, 32'h101F, 32'h0000_0017);
        cfg(UNIT_SHARED, 0, 32'h2000, 32'h0002_0007);
        cfg(UNIT_PERIPH, 0, 32'h3000, 32'hFFFF_0537);
        apb(1'b1, OFF_CTRL, 32'h0000_0047);
        rd(OFF_CTRL, 32'h0000_0047);
        rd(12'h178, 32'h0000_1000);
        rd(12'h304, 32'hFFFF_0537);
        for (int i = 0; i < 9; i++) begin
            u_mst.send(i % 3, T_ADDR[i], T_ATTR[i], T_PER[i], err);
            chk_bit(err, T_ERR[i]);
            rd(OFF_STATUS, {29'h0, T_ST[i]});
            apb(1'b1, OFF_STATUS, 32'h0000_0007);
        end
        // last refusal came from the peripheral guard on a miss
        rd(OFF_FADDR, 32'h0000_4000);
        rd(OFF_FINFO, 32'h0000_0200);
        // execute request into a region without execute permission
        u_mst.send(2, 32'h1000, 9'h171, 1'b0, err);
        chk_bit(err, 1'b1);
        rd(OFF_STATUS, 32'h0000_0001);
        apb(1'b1, OFF_STATUS, 32'h0000_0001);
        // masked shared fault stays quiet, unmasked master fault raises irq
        apb(1'b1, OFF_MASK, 32'h0000_0001);
        u_mst.send(0, 32'h2000, 9'h0B2, 1'b0, err);
        rd(OFF_STATUS, 32'h0000_0002);
        chk_bit(irq, 1'b0);
        u_mst.send(1, 32'h1020, 9'h0B1, 1'b0, err);
        rd(OFF_STATUS, 32'h0000_0003);
        chk_bit(irq, 1'b1);
        rd(OFF_FADDR, 32'h0000_1020);
        rd(OFF_FINFO, 32'h0000_0023);
        apb(1'b1, OFF_STATUS, 32'h0000_0001);
        rd(OFF_STATUS, 32'h0000_0002);
        chk_bit(irq, 1'b0);
        final_report();
    end
endmodule : bus_transfer_protection_unit_tb_top
`default_nettype wire
